// file: core/aict_pkg.sv
package aict_pkg;

  // ----------------------------------------------------------------
  // Register map, byte addresses
  // ----------------------------------------------------------------
  localparam logic [7:0] ADDR_CTRL   = 8'h00;
  localparam logic [7:0] ADDR_TRIG   = 8'h04;
  localparam logic [7:0] ADDR_STATUS = 8'h08;
  localparam logic [7:0] ADDR_COUNT  = 8'h0c;

  // ----------------------------------------------------------------
  // Field positions
  // ----------------------------------------------------------------
  localparam int CTRL_CH_LSB   = 0;
  localparam int CTRL_CLK_LSB  = 8;
  localparam int CTRL_DIV_LSB  = 10;
  localparam int CTRL_TEN_BIT  = 12;
  localparam int CTRL_SPK_BIT  = 13;
  localparam int TRIG_SEL_LSB  = 0;
  localparam int TRIG_DLY_LSB  = 8;

  // ----------------------------------------------------------------
  // Reset values
  // ----------------------------------------------------------------
  localparam logic [4:0] CH_RESET  = 5'h1f;
  localparam logic [1:0] CLK_RESET = 2'h0;
  localparam logic [1:0] DIV_RESET = 2'h0;
  localparam logic [7:0] DLY_RESET = 8'h00;

  // ----------------------------------------------------------------
  // Channel codes
  // ----------------------------------------------------------------
  localparam logic [4:0] CH_PIN_LAST  = 5'h0b;
  localparam logic [4:0] CH_PIN10     = 5'h0a;
  localparam logic [4:0] CH_GND_FIRST = 5'h0c;
  localparam logic [4:0] CH_GND_LAST  = 5'h12;
  localparam logic [4:0] CH_TEMP      = 5'h16;
  localparam logic [4:0] CH_BANDGAP   = 5'h17;
  localparam logic [4:0] CH_HIGH_RAIL = 5'h1d;
  localparam logic [4:0] CH_LOW_RAIL  = 5'h1e;
  localparam logic [4:0] CH_DISABLE   = 5'h1f;

  typedef enum logic [2:0] {
    AICT_IN_PIN, AICT_IN_GND, AICT_IN_RSVD, AICT_IN_TEMP,
    AICT_IN_BG, AICT_IN_VRH, AICT_IN_VRL, AICT_IN_NONE
  } aict_input_t;

  typedef enum logic [1:0] {
    AICT_CLK_BUS, AICT_CLK_BUS_HALF, AICT_CLK_LOCAL, AICT_CLK_ALT
  } aict_clk_src_t;

  typedef enum logic [1:0] {
    AICT_TRG_MOD_TIMER, AICT_TRG_RTC, AICT_TRG_PWM_MATCH, AICT_TRG_PWM_INIT
  } aict_trig_src_t;

  typedef enum logic [1:0] {
    AICT_MODE_RUN, AICT_MODE_WAIT, AICT_MODE_DEEP_STOP
  } aict_power_t;

  typedef struct packed {
    logic        en;
    aict_input_t kind;
    logic [3:0]  pin;
  } aict_route_t;

endpackage : aict_pkg

// file: core/aict_trig_delay.sv
`timescale 1ns/1ps
`default_nettype none

// Counts down a programmed number of bus cycles after a source pulse, then
// emits one pulse. A new source pulse while counting restarts the delay.
module aict_trig_delay (
  input  wire logic       i_sys_clk,
  input  wire logic       i_reset,
  input  wire logic       i_ce,
  input  wire logic       i_pulse,
  input  wire logic [7:0] i_delay,
  output logic            o_pulse
);

  typedef struct packed {
    logic       busy;
    logic [7:0] cnt;
    logic       out;
  } aict_dly_state_t;

  aict_dly_state_t st_q;
  aict_dly_state_t st_d;

  always_comb begin
    st_d     = st_q;
    st_d.out = 1'b0;
    if (i_pulse) begin
      if (i_delay == 8'h00) begin
        st_d.out  = 1'b1;
        st_d.busy = 1'b0;
      end else begin
        st_d.busy = 1'b1;
        st_d.cnt  = i_delay;
      end
    end else if (st_q.busy) begin
      if (st_q.cnt == 8'h01) begin
        st_d.busy = 1'b0;
        st_d.out  = 1'b1;
      end
      st_d.cnt = st_q.cnt - 8'h01;
    end
  end

  always_ff @(posedge i_sys_clk) begin
    if (i_reset) begin
      st_q <= '0;
    end else if (i_ce) begin
      st_q <= st_d;
    end
  end

  assign o_pulse = st_q.out;

endmodule : aict_trig_delay
`default_nettype wire

// file: core/aict_top.sv
// Added by the designer: the register addresses and the AXI4-Lite interface to the registers.
`timescale 1ns/1ps
`default_nettype none

// Operation
// - Codes 0 to 11 route the twelve pins in order, 10 and 11 go to ground on the small package, 12 to 18 ground.
// - Reserved codes still start conversions, flagged as reserved with undefined result.
// - Codes 22, 23, 29 and 30 pick temperature, bandgap, high and low reference rail.
// - Code 31 disables the converter: no input and no conversion.
// - The conversion clock source is bus, bus halved, local async, or the oscillator output.
// - The chosen source is divided by the divide-select field to form the conversion clock.
// - The alternate clock stays usable in wait mode.
// - In deep stop the alternate clock is not a usable conversion clock.
// - Triggers are modulo timer, RTC, and the two pwm timer triggers each after an 8-bit delay.
// - All four triggers work in run and wait modes.
// - In deep stop only the RTC overflow may trigger.
module aict_top (
  input  wire logic                 i_sys_clk,
  input  wire logic                 i_reset,
  input  wire logic                 i_ce,
  input  wire logic                 i_small_package,
  input  wire logic [1:0]           i_power_mode,
  input  wire logic                 i_local_async_conv_clock,
  input  wire logic                 i_external_osc_output,
  input  wire logic                 i_modulo_timer_zero_ovf,
  input  wire logic                 i_rtc_ovf,
  input  wire logic                 i_pwm_timer_two_match,
  input  wire logic                 i_pwm_timer_two_init,
  input  wire logic [7:0]           s_axi_awaddr,
  input  wire logic                 s_axi_awvalid,
  output logic                      s_axi_awready,
  input  wire logic [31:0]          s_axi_wdata,
  input  wire logic [3:0]           s_axi_wstrb,
  input  wire logic                 s_axi_wvalid,
  output logic                      s_axi_wready,
  output logic [1:0]                s_axi_bresp,
  output logic                      s_axi_bvalid,
  input  wire logic                 s_axi_bready,
  input  wire logic [7:0]           s_axi_araddr,
  input  wire logic                 s_axi_arvalid,
  output logic                      s_axi_arready,
  output logic [31:0]               s_axi_rdata,
  output logic [1:0]                s_axi_rresp,
  output logic                      s_axi_rvalid,
  input  wire logic                 s_axi_rready,
  output aict_pkg::aict_route_t     o_route,
  output logic                      o_conversion_clock,
  output logic                      o_conv_start,
  output logic                      o_result_undefined
);

  // ----------------------------------------------------------------
  // State
  // ----------------------------------------------------------------
  typedef struct packed {
    logic [4:0]  channel_select;
    logic [1:0]  clk_src;
    logic [1:0]  clock_divide_select;
    logic        trig_en;
    logic        sw_start;
    logic [1:0]  trig_sel;
    logic [7:0]  dly_match;
    logic [7:0]  dly_init;
    logic        aw_seen;
    logic        w_seen;
    logic [7:0]  awaddr;
    logic [31:0] wdata;
    logic [3:0]  wstrb;
    logic        bvalid;
    logic        rvalid;
    logic [31:0] rdata;
    logic [1:0]  rresp;
    logic [1:0]  bresp;
    logic [2:0]  sync_local;
    logic [2:0]  sync_alt;
    logic        half;
    logic [6:0]  div_cnt;
    logic        conv_clk;
    logic        conv_clk_prev;
    logic        pend;
    logic        start;
    logic        undef;
    aict_pkg::aict_route_t route;
    logic [15:0] started;
  } aict_state_t;

  aict_state_t st_q;
  aict_state_t st_d;

  logic       pulse_match;
  logic       pulse_init;
  logic [1:0] sync_mode_q;
  logic [1:0] sync_mode_qq;
  logic [3:0] trig_in_q;
  logic [3:0] trig_in_qq;
  logic [3:0] trig_in_prev;
  logic       small_pkg_q;
  logic       small_pkg_qq;

  // ----------------------------------------------------------------
  // Pin inputs: two flops each before use
  // ----------------------------------------------------------------
  always_ff @(posedge i_sys_clk) begin
    if (i_reset) begin
      sync_mode_q  <= 2'h0;
      sync_mode_qq <= 2'h0;
      trig_in_q    <= 4'h0;
      trig_in_qq   <= 4'h0;
      trig_in_prev <= 4'h0;
      small_pkg_q  <= 1'b0;
      small_pkg_qq <= 1'b0;
    end else if (i_ce) begin
      sync_mode_q  <= i_power_mode;
      sync_mode_qq <= sync_mode_q;
      trig_in_q    <= {i_pwm_timer_two_init, i_pwm_timer_two_match, i_rtc_ovf,
                       i_modulo_timer_zero_ovf};
      trig_in_qq   <= trig_in_q;
      trig_in_prev <= trig_in_qq;
      small_pkg_q  <= i_small_package;
      small_pkg_qq <= small_pkg_q;
    end
  end

  logic [3:0] trig_rise;
  logic       deep_stop;
  logic       chan_on;
  assign trig_rise = trig_in_qq & ~trig_in_prev;
  // Gating on the stored code, not on the route register, keeps a disable
  // from letting one last start slip through while the route catches up.
  assign chan_on   = (st_q.channel_select != aict_pkg::CH_DISABLE);
  assign deep_stop = (sync_mode_qq == 2'(aict_pkg::AICT_MODE_DEEP_STOP));

  aict_trig_delay u_dly_match (
    .i_sys_clk (i_sys_clk),
    .i_reset   (i_reset),
    .i_ce      (i_ce),
    .i_pulse   (trig_rise[2]),
    .i_delay   (st_q.dly_match),
    .o_pulse   (pulse_match)
  );

  aict_trig_delay u_dly_init (
    .i_sys_clk (i_sys_clk),
    .i_reset   (i_reset),
    .i_ce      (i_ce),
    .i_pulse   (trig_rise[3]),
    .i_delay   (st_q.dly_init),
    .o_pulse   (pulse_init)
  );

  // ----------------------------------------------------------------
  // Next state
  // ----------------------------------------------------------------
  logic        src_tick;
  logic        trig_hit;
  logic        do_write;
  logic [31:0] wmask;
  logic [31:0] ctrl_word;
  logic [31:0] trig_word;
  logic [6:0]  div_top;

  always_comb begin
    st_d = st_q;
    src_tick = 1'b0;
    trig_hit = 1'b0;
    wmask = '0;
    ctrl_word = '0;
    trig_word = '0;
    div_top = 7'h00;

    // Channel decode.
    st_d.route.en   = 1'b1;
    st_d.route.pin  = 4'h0;
    st_d.route.kind = aict_pkg::AICT_IN_RSVD;
    if (st_q.channel_select <= aict_pkg::CH_PIN_LAST) begin
      st_d.route.kind = aict_pkg::AICT_IN_PIN;
      st_d.route.pin  = st_q.channel_select[3:0];
      if (small_pkg_qq && st_q.channel_select >= aict_pkg::CH_PIN10) begin
        st_d.route.kind = aict_pkg::AICT_IN_GND;
      end
    end else if (st_q.channel_select <= aict_pkg::CH_GND_LAST) begin
      st_d.route.kind = aict_pkg::AICT_IN_GND;
    end else begin
      case (st_q.channel_select)
        aict_pkg::CH_TEMP:    st_d.route.kind = aict_pkg::AICT_IN_TEMP;
        aict_pkg::CH_BANDGAP: st_d.route.kind = aict_pkg::AICT_IN_BG;
        aict_pkg::CH_HIGH_RAIL: st_d.route.kind = aict_pkg::AICT_IN_VRH;
        aict_pkg::CH_LOW_RAIL:  st_d.route.kind = aict_pkg::AICT_IN_VRL;
        aict_pkg::CH_DISABLE: begin
          st_d.route.kind = aict_pkg::AICT_IN_NONE;
          st_d.route.en   = 1'b0;
        end
        default: st_d.route.kind = aict_pkg::AICT_IN_RSVD;
      endcase
    end

    // Clock source and divider. Sources are edge-sampled on the bus clock,
    // so the conversion clock runs at no more than half the bus rate.
    st_d.sync_local = {st_q.sync_local[1:0], i_local_async_conv_clock};
    st_d.sync_alt   = {st_q.sync_alt[1:0], i_external_osc_output};
    st_d.half       = ~st_q.half;
    case (aict_pkg::aict_clk_src_t'(st_q.clk_src))
      aict_pkg::AICT_CLK_BUS:      src_tick = 1'b1;
      aict_pkg::AICT_CLK_BUS_HALF: src_tick = st_q.half;
      aict_pkg::AICT_CLK_LOCAL:    src_tick = st_q.sync_local[1] & ~st_q.sync_local[2];
      aict_pkg::AICT_CLK_ALT:      src_tick = st_q.sync_alt[1] & ~st_q.sync_alt[2]
                                              & ~deep_stop;
      default:                     src_tick = 1'b0;
    endcase
    case (st_q.clock_divide_select)
      2'h0:    div_top = 7'h00;
      2'h1:    div_top = 7'h01;
      2'h2:    div_top = 7'h03;
      default: div_top = 7'h07;
    endcase
    if (src_tick && st_q.route.en) begin
      if (st_q.div_cnt >= div_top) begin
        st_d.div_cnt  = 7'h00;
        st_d.conv_clk = ~st_q.conv_clk;
      end else begin
        st_d.div_cnt = st_q.div_cnt + 7'h01;
      end
    end
    st_d.conv_clk_prev = st_q.conv_clk;

    // Trigger selection.
    if (st_q.trig_en) begin
      case (aict_pkg::aict_trig_src_t'(st_q.trig_sel))
        aict_pkg::AICT_TRG_MOD_TIMER: trig_hit = trig_rise[0] & ~deep_stop;
        aict_pkg::AICT_TRG_RTC:       trig_hit = trig_rise[1];
        aict_pkg::AICT_TRG_PWM_MATCH: trig_hit = pulse_match & ~deep_stop;
        aict_pkg::AICT_TRG_PWM_INIT:  trig_hit = pulse_init & ~deep_stop;
        default:                      trig_hit = 1'b0;
      endcase
    end
    st_d.start = 1'b0;
    if ((trig_hit || st_q.sw_start) && chan_on) begin
      st_d.pend = 1'b1;
    end
    st_d.sw_start = 1'b0;
    if (st_q.pend && chan_on && st_q.conv_clk && !st_q.conv_clk_prev) begin
      st_d.start   = 1'b1;
      st_d.pend    = trig_hit || st_q.sw_start;
      st_d.undef   = (st_q.route.kind == aict_pkg::AICT_IN_RSVD);
      st_d.started = st_q.started + 16'h0001;
    end
    if (!chan_on) begin
      st_d.pend = 1'b0;
    end

    // AXI4-Lite write.
    if (s_axi_awvalid && !st_q.aw_seen) begin
      st_d.aw_seen = 1'b1;
      st_d.awaddr  = s_axi_awaddr;
    end
    if (s_axi_wvalid && !st_q.w_seen) begin
      st_d.w_seen = 1'b1;
      st_d.wdata  = s_axi_wdata;
      st_d.wstrb  = s_axi_wstrb;
    end
    do_write = st_q.aw_seen && st_q.w_seen && !st_q.bvalid;
    for (int b = 0; b < 4; b++) begin
      wmask[b*8 +: 8] = {8{st_q.wstrb[b]}};
    end
    ctrl_word = {18'h0, 1'b0, st_q.trig_en, st_q.clock_divide_select, st_q.clk_src,
                 3'h0, st_q.channel_select};
    trig_word = {8'h0, st_q.dly_init, st_q.dly_match, 6'h0, st_q.trig_sel};
    if (do_write) begin
      st_d.aw_seen = 1'b0;
      st_d.w_seen  = 1'b0;
      st_d.bvalid  = 1'b1;
      st_d.bresp   = 2'h0;
      case (st_q.awaddr)
        aict_pkg::ADDR_CTRL: begin
          ctrl_word = (ctrl_word & ~wmask) | (st_q.wdata & wmask);
          st_d.channel_select      = ctrl_word[aict_pkg::CTRL_CH_LSB +: 5];
          st_d.clk_src             = ctrl_word[aict_pkg::CTRL_CLK_LSB +: 2];
          st_d.clock_divide_select = ctrl_word[aict_pkg::CTRL_DIV_LSB +: 2];
          st_d.trig_en             = ctrl_word[aict_pkg::CTRL_TEN_BIT];
          st_d.sw_start            = ctrl_word[aict_pkg::CTRL_SPK_BIT];
        end
        aict_pkg::ADDR_TRIG: begin
          trig_word = (trig_word & ~wmask) | (st_q.wdata & wmask);
          st_d.trig_sel  = trig_word[aict_pkg::TRIG_SEL_LSB +: 2];
          st_d.dly_match = trig_word[aict_pkg::TRIG_DLY_LSB +: 8];
          st_d.dly_init  = trig_word[aict_pkg::TRIG_DLY_LSB + 8 +: 8];
        end
        aict_pkg::ADDR_STATUS, aict_pkg::ADDR_COUNT: st_d.bresp = 2'h0;
        default: st_d.bresp = 2'h2;
      endcase
    end
    if (st_q.bvalid && s_axi_bready) begin
      st_d.bvalid = 1'b0;
    end

    // AXI4-Lite read.
    if (s_axi_arvalid && !st_q.rvalid) begin
      st_d.rvalid = 1'b1;
      st_d.rresp  = 2'h0;
      case (s_axi_araddr)
        aict_pkg::ADDR_CTRL:   st_d.rdata = ctrl_word;
        aict_pkg::ADDR_TRIG:   st_d.rdata = trig_word;
        aict_pkg::ADDR_STATUS: st_d.rdata = {24'h0, st_q.undef, st_q.pend, deep_stop,
                                             st_q.route.en, 1'b0, 3'(st_q.route.kind)};
        aict_pkg::ADDR_COUNT:  st_d.rdata = {16'h0, st_q.started};
        default: begin
          st_d.rdata = 32'h0;
          st_d.rresp = 2'h2;
        end
      endcase
    end else if (st_q.rvalid && s_axi_rready) begin
      st_d.rvalid = 1'b0;
    end
  end

  always_ff @(posedge i_sys_clk) begin
    if (i_reset) begin
      st_q                     <= '0;
      st_q.channel_select      <= aict_pkg::CH_RESET;
      st_q.clk_src             <= aict_pkg::CLK_RESET;
      st_q.clock_divide_select <= aict_pkg::DIV_RESET;
      st_q.dly_match           <= aict_pkg::DLY_RESET;
      st_q.dly_init            <= aict_pkg::DLY_RESET;
      st_q.route.kind          <= aict_pkg::AICT_IN_NONE;
    end else if (i_ce) begin
      st_q <= st_d;
    end
  end

  // ----------------------------------------------------------------
  // Outputs
  // ----------------------------------------------------------------
  assign s_axi_awready      = !st_q.aw_seen;
  assign s_axi_wready       = !st_q.w_seen;
  assign s_axi_bvalid       = st_q.bvalid;
  assign s_axi_bresp        = st_q.bresp;
  assign s_axi_arready      = !st_q.rvalid;
  assign s_axi_rvalid       = st_q.rvalid;
  assign s_axi_rdata        = st_q.rdata;
  assign s_axi_rresp        = st_q.rresp;
  assign o_route            = st_q.route;
  assign o_conversion_clock = st_q.conv_clk;
  assign o_conv_start       = st_q.start;
  assign o_result_undefined = st_q.undef;

  // ----------------------------------------------------------------
  // Assertions
  // ----------------------------------------------------------------
  a_disable_no_start: assert property (
    @(posedge i_sys_clk) disable iff (i_reset)
    !st_q.route.en |-> !st_q.start && !st_q.pend)
    else $error("Conversion started while module disabled.");
  a_disable_code: assert property (
    @(posedge i_sys_clk) disable iff (i_reset)
    i_ce && $past(i_ce) && $past(st_q.channel_select) == aict_pkg::CH_DISABLE
    |-> !st_q.route.en)
    else $error("Disable code did not disable the route.");
  a_temp_route: assert property (
    @(posedge i_sys_clk) disable iff (i_reset)
    i_ce && st_q.channel_select == aict_pkg::CH_TEMP
    |=> !i_ce || st_q.route.kind == aict_pkg::AICT_IN_TEMP || $changed(st_q.channel_select))
    else $error("Temperature code routed wrongly.");
  a_pin_route: assert property (
    @(posedge i_sys_clk) disable iff (i_reset)
    i_ce && !i_small_package && st_q.channel_select <= aict_pkg::CH_PIN_LAST
    && $stable(st_q.channel_select) && $past(i_ce)
    |-> st_q.route.pin == st_q.channel_select[3:0] || st_q.route.kind != aict_pkg::AICT_IN_PIN)
    else $error("Pin code routed to the wrong pin.");
  a_gnd_route: assert property (
    @(posedge i_sys_clk) disable iff (i_reset)
    i_ce && st_q.channel_select >= aict_pkg::CH_GND_FIRST
    && st_q.channel_select <= aict_pkg::CH_GND_LAST ##1 i_ce && $stable(st_q.channel_select)
    |-> st_q.route.kind == aict_pkg::AICT_IN_GND)
    else $error("Ground code not routed to ground.");
  a_start_on_edge: assert property (
    @(posedge i_sys_clk) disable iff (i_reset)
    st_q.start |-> $past(st_q.pend) && st_q.conv_clk_prev)
    else $error("Start not aligned to conversion clock.");
  a_start_single: assert property (
    @(posedge i_sys_clk) disable iff (i_reset)
    i_ce && st_q.start |=> !i_ce || !st_q.start)
    else $error("Start lasted more than one cycle.");
  a_deep_stop_alt: assert property (
    @(posedge i_sys_clk) disable iff (i_reset)
    deep_stop && st_q.clk_src == 2'(aict_pkg::AICT_CLK_ALT) |-> !src_tick)
    else $error("Alternate clock ticked in deep stop.");
  a_deep_stop_trig: assert property (
    @(posedge i_sys_clk) disable iff (i_reset)
    deep_stop && trig_hit |-> st_q.trig_sel == 2'(aict_pkg::AICT_TRG_RTC))
    else $error("Non-RTC trigger accepted in deep stop.");
  a_reserved_flag: assert property (
    @(posedge i_sys_clk) disable iff (i_reset)
    i_ce && st_q.pend && chan_on && st_q.conv_clk && !st_q.conv_clk_prev
    |=> st_q.undef == ($past(st_q.route.kind) == aict_pkg::AICT_IN_RSVD))
    else $error("Reserved flag wrong after start.");

endmodule : aict_top
`default_nettype wire

// file: testbench/aict_partner.sv
`timescale 1ns/1ps
`default_nettype none

// Far side: free-running clock sources and the timer trigger lines.
module aict_partner (
  input  wire logic       i_sys_clk,
  input  wire logic [3:0] i_fire,
  output logic            o_local_clk,
  output logic            o_osc_clk,
  output logic [3:0]      o_trig
);
  logic [2:0] cnt_q [4] = '{default: 3'h0};

  initial o_local_clk = 1'b0;
  initial o_osc_clk = 1'b0;
  initial o_trig = 4'h0;
  always #7 o_local_clk = ~o_local_clk;
  always #11 o_osc_clk = ~o_osc_clk;

  // A request becomes a four-cycle pulse, wide enough for a two-flop synchroniser.
  always @(posedge i_sys_clk) begin
    for (int k = 0; k < 4; k++) begin
      if (i_fire[k]) cnt_q[k] <= 3'h4;
      else if (cnt_q[k] != 3'h0) cnt_q[k] <= cnt_q[k] - 3'h1;
      o_trig[k] <= cnt_q[k] != 3'h0;
    end
  end
endmodule : aict_partner

`default_nettype wire

// file: testbench/tb.sv
`timescale 1ns/1ps
`default_nettype none

module tb;
  logic        clk = 1'b0;
  logic        rst = 1'b1;
  logic        small_pkg = 1'b0;
  logic [1:0]  pmode = 2'h0;
  logic [3:0]  fire = 4'h0;
  logic [7:0]  awaddr = 8'h00;
  logic [7:0]  araddr = 8'h00;
  logic [31:0] wdata = 32'h0;
  logic        awvalid = 1'b0;
  logic        wvalid = 1'b0;
  logic        bready = 1'b0;
  logic        arvalid = 1'b0;
  logic        rready = 1'b0;
  logic        awready, wready, bvalid, arready, rvalid;
  logic [1:0]  bresp, rresp;
  logic [31:0] rdata;
  logic        lclk, oclk, cclk, cstart, undef;
  logic [3:0]  trig;
  int          bad_count = 0;
  int          n_checks = 0;
  int          cyc = 0;
  aict_pkg::aict_route_t route;

  initial forever #2 clk = ~clk;

  aict_partner u_far (.i_sys_clk(clk), .i_fire(fire), .o_local_clk(lclk),
    .o_osc_clk(oclk), .o_trig(trig));

  aict_top u_dut (.i_sys_clk(clk), .i_reset(rst), .i_ce(1'b1),
    .i_small_package(small_pkg), .i_power_mode(pmode),
    .i_local_async_conv_clock(lclk), .i_external_osc_output(oclk),
    .i_modulo_timer_zero_ovf(trig[0]), .i_rtc_ovf(trig[1]),
    .i_pwm_timer_two_match(trig[2]), .i_pwm_timer_two_init(trig[3]),
    .s_axi_awaddr(awaddr), .s_axi_awvalid(awvalid), .s_axi_awready(awready),
    .s_axi_wdata(wdata), .s_axi_wstrb(4'hf), .s_axi_wvalid(wvalid),
    .s_axi_wready(wready), .s_axi_bresp(bresp), .s_axi_bvalid(bvalid),
    .s_axi_bready(bready), .s_axi_araddr(araddr), .s_axi_arvalid(arvalid),
    .s_axi_arready(arready), .s_axi_rdata(rdata), .s_axi_rresp(rresp),
    .s_axi_rvalid(rvalid), .s_axi_rready(rready), .o_route(route),
    .o_conversion_clock(cclk), .o_conv_start(cstart),
    .o_result_undefined(undef));

  // ------------------------------------------------------------
  // Shared tasks
  // ------------------------------------------------------------
  task automatic give_verdict();
    if (bad_count == 0 && n_checks > 0) $display("Result: passed");
    else $display("Result: failed");
    $finish;
  endtask : give_verdict

  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    n_checks++;
    if (got !== exp) begin
      bad_count++;
      $display("BAD t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask : chk

  task automatic axi_wr(input logic [7:0] a, input logic [31:0] d, input logic [1:0] er);
    awaddr <= a;
    wdata <= d;
    awvalid <= 1'b1;
    wvalid <= 1'b1;
    bready <= 1'b1;
    do begin
      @(posedge clk);
      if (awvalid && awready) awvalid <= 1'b0;
      if (wvalid && wready) wvalid <= 1'b0;
    end while (bvalid !== 1'b1);
    bready <= 1'b0;
    chk(32'(bresp), 32'(er));
    @(posedge clk);
  endtask : axi_wr

  task automatic axi_rd(input logic [7:0] a, output logic [31:0] d, output logic [1:0] r);
    araddr <= a;
    arvalid <= 1'b1;
    rready <= 1'b1;
    do begin
      @(posedge clk);
      if (arvalid && arready) arvalid <= 1'b0;
    end while (rvalid !== 1'b1);
    d = rdata;
    r = rresp;
    rready <= 1'b0;
    @(posedge clk);
  endtask : axi_rd

  // Counts start pulses and conversion clock changes over 128 cycles.
  task automatic watch(output int ns, output int nt);
    logic last;
    ns = 0;
    nt = 0;
    last = cclk;
    repeat (128) begin
      @(posedge clk);
      if (cstart === 1'b1) ns++;
      if (cclk !== last) nt++;
      last = cclk;
    end
  endtask : watch

  function automatic logic [3:0] kind_exp(input logic [4:0] c, input logic sp);
    case (c) inside
      [5'h00:5'h09]: return 4'h8;
      [5'h0a:5'h0b]: return sp ? 4'h9 : 4'h8;
      [5'h0c:5'h12]: return 4'h9;
      5'h16: return 4'hb;
      5'h17: return 4'hc;
      5'h1d: return 4'hd;
      5'h1e: return 4'he;
      5'h1f: return 4'h7;
      default: return 4'ha;
    endcase
  endfunction : kind_exp

  // ------------------------------------------------------------
  // Scenarios
  // ------------------------------------------------------------
  task automatic sw_case(input logic [4:0] ch, input logic [3:0] cfg, input int exp_n,
                         input logic exp_u);
    int ns;
    int nt;
    axi_wr(aict_pkg::ADDR_CTRL, 32'h2000 | {20'h0, cfg, 8'h0} | 32'(ch), 2'h0);
    watch(ns, nt);
    chk(32'(ns), 32'(exp_n));
    if (exp_n > 0) chk(32'(undef), 32'(exp_u));
  endtask : sw_case

  // Local clock is used so the deep stop case still has a running source.
  task automatic trig_case(input logic [1:0] md, input logic [1:0] src, input int exp_n);
    int ns;
    int nt;
    pmode <= md;
    axi_wr(aict_pkg::ADDR_TRIG, {16'h0303, 8'h0, 6'h0, src}, 2'h0);
    axi_wr(aict_pkg::ADDR_CTRL, 32'h1200, 2'h0);
    repeat (4) @(posedge clk);
    fire <= 4'(1 << src);
    @(posedge clk);
    fire <= 4'h0;
    watch(ns, nt);
    chk(32'(ns), 32'(exp_n));
  endtask : trig_case

  task automatic clk_case(input logic [1:0] md, input logic [3:0] cfg, input int lo, input int hi);
    int ns;
    int nt;
    pmode <= md;
    axi_wr(aict_pkg::ADDR_CTRL, {20'h0, cfg, 8'h0}, 2'h0);
    repeat (8) @(posedge clk);
    watch(ns, nt);
    chk(32'(nt >= lo && nt <= hi), 32'h1);
  endtask : clk_case

  always @(posedge clk) begin
    cyc <= cyc + 1;
    if (cyc == 20000) begin
      bad_count++;
      give_verdict();
    end
  end

  initial begin
    logic [31:0] d;
    logic [1:0]  r;
    repeat (5) @(posedge clk);
    rst <= 1'b0;
    @(posedge clk);
    axi_rd(aict_pkg::ADDR_CTRL, d, r);
    chk(d, 32'h1f);
    chk(32'({route.en, route.kind}), 32'h7);
    axi_rd(8'h20, d, r);
    chk(d | 32'(r), 32'h2);
    axi_wr(8'h30, 32'h0, 2'h2);
    for (int s = 0; s < 2; s++) begin
      small_pkg <= s[0];
      for (int c = 0; c < 32; c++) begin
        axi_wr(aict_pkg::ADDR_CTRL, 32'(c), 2'h0);
        repeat (2) @(posedge clk);
        chk(32'({route.en, route.kind}), 32'(kind_exp(c[4:0], s[0])));
        if (c < 10 || (c < 12 && s == 0)) chk(32'(route.pin), 32'(c[3:0]));
      end
    end
    sw_case(5'h13, 4'h0, 1, 1'b1);
    sw_case(5'h1f, 4'h0, 0, 1'b0);
    // Bandgap first, then temperature, on the slowest divider.
    sw_case(aict_pkg::CH_BANDGAP, 4'hc, 1, 1'b0);
    sw_case(aict_pkg::CH_TEMP, 4'hc, 1, 1'b0);
    axi_rd(aict_pkg::ADDR_STATUS, d, r);
    chk(d, 32'h13);
    axi_rd(aict_pkg::ADDR_COUNT, d, r);
    chk(d, 32'h3);
    for (int m = 0; m < 3; m++) begin
      for (int t = 0; t < 4; t++) begin
        trig_case(m[1:0], t[1:0], (m < 2 || t == 1) ? 1 : 0);
      end
    end
    for (int v = 0; v < 4; v++) begin
      clk_case(2'h0, {v[1:0], 2'h0}, (128 >> v) - 1, (128 >> v) + 1);
    end
    clk_case(2'h0, 4'h1, 63, 65);
    clk_case(2'h0, 4'h2, 20, 45);
    clk_case(2'h1, 4'h3, 10, 40);
    clk_case(2'h2, 4'h3, 0, 0);
    give_verdict();
  end
endmodule : tb

`default_nettype wire
